// File: logic/stc_pkg.sv
// package: constants and types for the switch timing control register
package stc_pkg;

  // ============================================================
  // register map and bus widths
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 16;
  localparam logic [ADDR_W-1:0] MAIN_CONTROL_ADDR = 12'h000;
  localparam logic [DATA_W-1:0] MAIN_CONTROL_RST = 16'h0000;
  localparam logic [DATA_W-1:0] UNMAPPED_RDATA = 16'h0000;

  // ============================================================
  // field positions inside main_control
  localparam int unsigned BOUNDARY_MODE_SELECT_BIT = 15;
  localparam int unsigned PLL_BYPASS_SELECT_BIT = 14;
  localparam int unsigned BOUNDARY_DETECT_ENABLE_BIT = 13;
  localparam int unsigned INPUT_CLOCK_SELECT_MSB = 12;
  localparam int unsigned INPUT_CLOCK_SELECT_LSB = 10;
  localparam int unsigned OUT_PAIR2_RATE_SELECT_BIT = 9;
  localparam int unsigned OUT_PAIR1_RATE_SELECT_BIT = 8;
  localparam int unsigned OUT_PAIR0_RATE_SELECT_BIT = 7;
  localparam int unsigned NUM_OUT_PAIRS = 3;

  // ============================================================
  // input clock select codes
  localparam logic [2:0] INCLK_CODE_16M = 3'h0;
  localparam logic [2:0] INCLK_CODE_8M = 3'h1;
  localparam logic [2:0] INCLK_CODE_4M = 3'h2;

  // ============================================================
  // rates in kHz and frame pulse widths in ns
  localparam logic [15:0] RATE_32768_KHZ = 16'h8000;
  localparam logic [15:0] RATE_16384_KHZ = 16'h4000;
  localparam logic [15:0] RATE_8192_KHZ = 16'h2000;
  localparam logic [15:0] RATE_4096_KHZ = 16'h1000;
  localparam logic [15:0] RATE_NONE_KHZ = 16'h0000;
  localparam logic [7:0] PULSE_30_NS = 8'h1E;
  localparam logic [7:0] PULSE_61_NS = 8'h3D;
  localparam logic [7:0] PULSE_122_NS = 8'h7A;
  localparam logic [7:0] PULSE_244_NS = 8'hF4;
  localparam logic [7:0] PULSE_NONE_NS = 8'h00;

  // ============================================================
  // jitter tolerance of the discriminator, in ns and in clock cycles
  localparam int unsigned SYS_CLK_PERIOD_NS = 10;
  localparam int unsigned JITTER_TOL_NS = 20;
  localparam int unsigned JITTER_TOL_RAW = JITTER_TOL_NS / SYS_CLK_PERIOD_NS;
  localparam logic [3:0] JITTER_TOL_CYCLES =
    4'(JITTER_TOL_RAW < 1 ? 1 : JITTER_TOL_RAW);
  localparam logic [3:0] JITTER_NONE_CYCLES = 4'h0;

  // ============================================================
  // types
  typedef enum logic [1:0] {
    INCLK_16M,
    INCLK_8M,
    INCLK_4M,
    INCLK_RESERVED
  } stc_inclk_e;

  typedef struct packed {
    logic [15:0] clock_khz;
    logic [7:0]  pulse_ns;
  } stc_pair_s;

  typedef struct packed {
    logic        discriminator_enable;
    logic [3:0]  jitter_window_cycles;
    logic        pll_bypass;
    stc_inclk_e  input_clock_mode;
    logic [15:0] input_clock_khz;
    logic [7:0]  input_pulse_low_ns;
  } stc_timing_s;

endpackage : stc_pkg

// File: logic/stc_main_control.sv
// module: main control register of the time-slot switch timing block
// Functional notes
// - discriminator on only when mode-select bit 15 and enable bit 13 high
// - enabled discriminator tolerates 20 ns input clock and pulse jitter
// - reset clears both discriminator bits, discriminator starts disabled
// - bit 14 low runs the pll free; high bypasses it to system timing
// - bits 12..10 pick input clock 16.384/8.192/4.096 MHz, others reserved
// - bit 9 picks pair two: 32.768 MHz/30 ns or 16.384 MHz/61 ns
// - bit 8 picks pair one: 16.384 MHz/61 ns or 8.192 MHz/122 ns
// - bit 7 picks pair zero: 4.096 MHz/244 ns or 8.192 MHz/122 ns
`timescale 1ns/10ps
`default_nettype none

module stc_main_control
  import stc_pkg::*;
(
  input  wire logic              sys_clk_in,
  input  wire logic              rst_in,
  input  wire logic              cpu_select_in,
  input  wire logic              cpu_write_in,
  input  wire logic [ADDR_W-1:0] cpu_addr_in,
  input  wire logic [DATA_W-1:0] cpu_wdata_in,
  output logic      [DATA_W-1:0] cpu_rdata_out,
  output logic                   cpu_ack_out,
  output stc_timing_s            timing_out,
  output stc_pair_s              pair_out [NUM_OUT_PAIRS],
  output logic                   input_select_reserved_out
);

  // ============================================================
  // register layout and access notes
  // bit 15     boundary_mode_select, half of the discriminator enable
  // bit 14     pll_bypass_select, high runs from system timing
  // bit 13     boundary_detect_enable, other half of the enable
  // bits 12:10 input_clock_select, codes above 010 are reserved
  // bit 9      out_pair2_rate_select
  // bit 8      out_pair1_rate_select
  // bit 7      out_pair0_rate_select
  // bits 6:0   kept as plain storage, no behaviour attached here
  //
  // the cpu port is a plain select/write/ack handshake: a request is
  // taken on a rising edge while select is high and ack is low, and
  // ack answers for exactly one cycle on the next edge
  // read data is registered and holds until the next taken read, so a
  // slow host may pick it up any time before its next access
  // decoded settings trail the stored word by one cycle; a user that
  // needs them on the write edge must decode the word itself
  // output rates are reported as numbers because the system clock
  // cannot build the listed output clocks directly
  // writes to any other address are dropped without any error flag;
  // reads of other addresses answer with zero
  // reserved input clock codes are stored as written, decode to zero
  // rate and width, and raise input_select_reserved_out for the system

  // ============================================================
  // decoding helpers
  // input clock code to mode; shared by the timing and flag paths
  // codes outside the table fall to the reserved mode
  function automatic stc_inclk_e decode_inclk(input logic [2:0] code);
    stc_inclk_e mode;
    mode = INCLK_RESERVED;
    if (code == INCLK_CODE_16M) begin
      mode = INCLK_16M;
    end else if (code == INCLK_CODE_8M) begin
      mode = INCLK_8M;
    end else if (code == INCLK_CODE_4M) begin
      mode = INCLK_4M;
    end
    return mode;
  endfunction : decode_inclk

  // one select bit and its two settings into a clock/pulse pair
  // both settings come from the caller so each table sits by its rule
  function automatic stc_pair_s pick_pair(input logic sel,
                                          input stc_pair_s low_set,
                                          input stc_pair_s high_set);
    stc_pair_s p;
    p = sel ? high_set : low_set;
    return p;
  endfunction : pick_pair

  // ============================================================
  // register bus
  logic [DATA_W-1:0] ctrl_r;
  logic [DATA_W-1:0] ctrl_nxt;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;
  logic              ack_r;
  logic              ack_nxt;
  logic              take;
  logic              hit;

  // a request is taken only while no ack is out, so a held select gives
  // one access every second cycle instead of repeated writes per cycle
  always_comb begin
    take = cpu_select_in & ~ack_r;
    hit = (cpu_addr_in == MAIN_CONTROL_ADDR);
    ctrl_nxt = ctrl_r;
    rdata_nxt = rdata_r;
    ack_nxt = take;
    if (take && cpu_write_in && hit) begin
      ctrl_nxt = cpu_wdata_in;
    end
    // unmapped reads answer zero so a stray address is easy to spot
    if (take && !cpu_write_in) begin
      rdata_nxt = hit ? ctrl_r : UNMAPPED_RDATA;
    end
  end

  // reset value clears the discriminator bits among the rest
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      ctrl_r  <= MAIN_CONTROL_RST;
      rdata_r <= UNMAPPED_RDATA;
      ack_r   <= 1'b0;
    end else begin
      ctrl_r  <= ctrl_nxt;
      rdata_r <= rdata_nxt;
      ack_r   <= ack_nxt;
    end
  end

  // bus answers come straight from flops, no combinational path
  assign cpu_rdata_out = rdata_r;
  assign cpu_ack_out = ack_r;

  // ============================================================
  // timing settings decoded from the stored value
  stc_timing_s timing_r;
  stc_timing_s timing_nxt;
  stc_pair_s   pair_r   [NUM_OUT_PAIRS];
  stc_pair_s   pair_nxt [NUM_OUT_PAIRS];
  logic        reserved_r;
  logic        reserved_nxt;
  logic [2:0]  inclk_code;
  logic [NUM_OUT_PAIRS-1:0] pair_sel;

  // fields pulled out of the stored word
  assign inclk_code = ctrl_r[INPUT_CLOCK_SELECT_MSB:INPUT_CLOCK_SELECT_LSB];
  assign pair_sel = {ctrl_r[OUT_PAIR2_RATE_SELECT_BIT],
                     ctrl_r[OUT_PAIR1_RATE_SELECT_BIT],
                     ctrl_r[OUT_PAIR0_RATE_SELECT_BIT]};

  // reserved codes give zero rate and width so downstream stays idle
  always_comb begin
    timing_nxt.discriminator_enable =
      ctrl_r[BOUNDARY_MODE_SELECT_BIT] &
      ctrl_r[BOUNDARY_DETECT_ENABLE_BIT];
    // window counted in system clock cycles, 20 ns over a 10 ns period
    timing_nxt.jitter_window_cycles =
      timing_nxt.discriminator_enable ? JITTER_TOL_CYCLES
                                      : JITTER_NONE_CYCLES;
    timing_nxt.pll_bypass = ctrl_r[PLL_BYPASS_SELECT_BIT];
    timing_nxt.input_clock_mode = decode_inclk(inclk_code);
    unique case (timing_nxt.input_clock_mode)
      INCLK_16M: begin
        timing_nxt.input_clock_khz = RATE_16384_KHZ;
        timing_nxt.input_pulse_low_ns = PULSE_61_NS;
      end
      INCLK_8M: begin
        timing_nxt.input_clock_khz = RATE_8192_KHZ;
        timing_nxt.input_pulse_low_ns = PULSE_122_NS;
      end
      INCLK_4M: begin
        timing_nxt.input_clock_khz = RATE_4096_KHZ;
        timing_nxt.input_pulse_low_ns = PULSE_244_NS;
      end
      INCLK_RESERVED: begin
        timing_nxt.input_clock_khz = RATE_NONE_KHZ;
        timing_nxt.input_pulse_low_ns = PULSE_NONE_NS;
      end
    endcase
    // flag lets the system see a host that broke the reserved-code rule
    reserved_nxt =
      (decode_inclk(inclk_code) == INCLK_RESERVED);
    pair_nxt[2] = pick_pair(pair_sel[2],
                            '{RATE_32768_KHZ, PULSE_30_NS},
                            '{RATE_16384_KHZ, PULSE_61_NS});
    pair_nxt[1] = pick_pair(pair_sel[1],
                            '{RATE_16384_KHZ, PULSE_61_NS},
                            '{RATE_8192_KHZ, PULSE_122_NS});
    pair_nxt[0] = pick_pair(pair_sel[0],
                            '{RATE_4096_KHZ, PULSE_244_NS},
                            '{RATE_8192_KHZ, PULSE_122_NS});
  end

  // settings are registered so they change one cycle after the write
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      timing_r <= '{1'b0, JITTER_NONE_CYCLES, 1'b0, INCLK_16M,
                    RATE_16384_KHZ, PULSE_61_NS};
      reserved_r <= 1'b0;
    end else begin
      timing_r <= timing_nxt;
      reserved_r <= reserved_nxt;
    end
  end

  // pairs reset to zero rather than to their decoded values, so
  // downstream logic sees an idle pair for one cycle after reset is
  // released before the stored word takes effect
  // one register per output pair
  genvar g;
  generate
    for (g = 0; g < NUM_OUT_PAIRS; g++) begin : g_pair
      always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
          pair_r[g] <= '{RATE_NONE_KHZ, PULSE_NONE_NS};
        end else begin
          pair_r[g] <= pair_nxt[g];
        end
      end
      assign pair_out[g] = pair_r[g];
    end
  endgenerate

  // ============================================================
  // output ports
  // ports show the registered settings only
  assign timing_out = timing_r;
  assign input_select_reserved_out = reserved_r;

endmodule : stc_main_control

`default_nettype wire

// File: sim/stc_host.sv
// host model: cpu port master for the main control register
`timescale 1ns/10ps
`default_nettype none
module stc_host import stc_pkg::*; (
  input  wire logic              sys_clk_in,
  input  wire logic              cpu_ack_in,
  input  wire logic [DATA_W-1:0] cpu_rdata_in,
  output var  logic              cpu_select_out = 1'b0,
  output var  logic              cpu_write_out  = 1'b0,
  output var  logic [ADDR_W-1:0] cpu_addr_out   = 12'h000,
  output var  logic [DATA_W-1:0] cpu_wdata_out  = 16'h0000
);
  // ==========================================================
  // bus access
  // normal running word keeps both discriminator bits high
  localparam logic [DATA_W-1:0] NORMAL_MODE = 16'hA000;

  // request held until ack is seen; released lines show inverted data
  task automatic access(input logic w, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d,
                        output logic [DATA_W-1:0] q);
    int n;
    n = 0;
    // reserved input clock codes are never sent; a write clears them to code 000
    if (w && d[12:10] > 3'h2) d[12:10] = 3'h0;
    @(negedge sys_clk_in);
    cpu_select_out = 1'b1;
    cpu_write_out = w;
    cpu_addr_out = a;
    cpu_wdata_out = d;
    do begin
      @(negedge sys_clk_in);
      n++;
    end while (cpu_ack_in !== 1'b1 && n < 8);
    if (cpu_ack_in !== 1'b1) begin
      tb_top.n_fail++;
      $display("BAD ack expected 1 seen %b", cpu_ack_in);
    end
    // ack drops on the next rising edge; release only after it
    @(negedge sys_clk_in);
    q = cpu_rdata_in;
    cpu_select_out = 1'b0;
    cpu_addr_out = ~a;
    cpu_wdata_out = ~d;
  endtask : access
endmodule : stc_host
`default_nettype wire

// File: sim/stc_monitor.sv
// checker: port assertions for the main control register
`timescale 1ns/10ps
`default_nettype none
module stc_mon import stc_pkg::*; (
  input wire logic              sys_clk_in,
  input wire logic              rst_in,
  input wire logic              cpu_select_in,
  input wire logic              cpu_write_in,
  input wire logic [ADDR_W-1:0] cpu_addr_in,
  input wire logic [DATA_W-1:0] cpu_wdata_in,
  input wire logic [DATA_W-1:0] cpu_rdata_out,
  input wire logic              cpu_ack_out,
  input wire stc_timing_s       timing_out,
  input wire stc_pair_s         pair_out [NUM_OUT_PAIRS],
  input wire logic              input_select_reserved_out
);
  // ==========================================================
  // shadow word; lag copy since outputs follow a write one cycle late
  logic [15:0] shd_r, shd_nxt, lag_r;
  logic        tk;
  logic        rst_d_r;
  assign tk = cpu_select_in & ~cpu_ack_out;
  always_comb begin
    shd_nxt = shd_r;
    if (tk & cpu_write_in & (cpu_addr_in == MAIN_CONTROL_ADDR)) begin
      shd_nxt = cpu_wdata_in;
    end
  end
  always_ff @(posedge sys_clk_in) begin
    shd_r <= rst_in ? 16'h0000 : shd_nxt;
    lag_r <= rst_in ? 16'h0000 : shd_r;
    rst_d_r <= rst_in;
  end
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  a_ack_one_pulse: assert property (
    tk |=> cpu_ack_out ##1 !cpu_ack_out)
    else $error("ack not a one cycle pulse");
  a_read_back: assert property (tk && !cpu_write_in &&
    cpu_addr_in == 12'h000 |=> cpu_rdata_out == shd_r) else $error("read");
  a_reset_clears: assert property (disable iff (1'b0) rst_in |=>
    !timing_out.discriminator_enable) else $error("reset disc");
  a_disc_both_bits: assert property (timing_out.discriminator_enable ==
    (lag_r[15] & lag_r[13])) else $error("disc enable");
  a_jitter_window: assert property (timing_out.discriminator_enable |->
    timing_out.jitter_window_cycles == 4'h2) else $error("jitter");
  a_pll_bypass: assert property (timing_out.pll_bypass == lag_r[14])
    else $error("bypass");
  a_input_rate: assert property (lag_r[12:10] < 3'h3 |->
    timing_out.input_clock_khz == (16'h4000 >> lag_r[12:10]) &&
    timing_out.input_pulse_low_ns == (8'h3D << lag_r[12:10]))
    else $error("input rate");
  // pairs sit at zero for the first cycle after reset is released
  a_out_pairs: assert property (!rst_d_r |->
    pair_out[2] == (lag_r[9] ? 24'h40003D : 24'h80001E) &&
    pair_out[1] == (lag_r[8] ? 24'h20007A : 24'h40003D) &&
    pair_out[0] == (lag_r[7] ? 24'h20007A : 24'h1000F4))
    else $error("output pairs");
  a_reserved_flag: assert property (input_select_reserved_out ==
    (lag_r[12:10] > 3'h2)) else $error("reserved flag");
  c_write: cover property (tk && cpu_write_in);
  c_reset_on: cover property (disable iff (1'b0)
    rst_in && timing_out.discriminator_enable);
  c_read: cover property (tk && !cpu_write_in);
  c_disc_on: cover property (timing_out.discriminator_enable);
endmodule : stc_mon
bind stc_main_control stc_mon stc_mon_i (.sys_clk_in, .rst_in,
  .cpu_select_in, .cpu_write_in, .cpu_addr_in, .cpu_wdata_in,
  .cpu_rdata_out, .cpu_ack_out, .timing_out, .pair_out,
  .input_select_reserved_out);
`default_nettype wire

// File: sim/tb_top.sv
// testbench: register writes, readback and decoded timing outputs
`timescale 1ns/10ps
`default_nettype none
module tb_top import stc_pkg::*;;
  logic              sys_clk_in = 1'b0;
  logic              rst_in     = 1'b1;
  logic              sel, wr, ack;
  logic              rsv;
  logic [ADDR_W-1:0] adr;
  logic [DATA_W-1:0] wd, rd, q, w;
  stc_timing_s       tim;
  stc_pair_s         pr [NUM_OUT_PAIRS];
  int                n_fail = 0;
  int                checks = 0;
  int                cyc    = 0;
  logic [15:0] words [4] = '{16'h0000, 16'hA3AA, 16'hC555, 16'h6AFF};
  // ==========================================================
  // clock, instances and helpers
  always #5 sys_clk_in = ~sys_clk_in;
  stc_main_control stc_main_control_i (.sys_clk_in, .rst_in,
    .cpu_select_in(sel), .cpu_write_in(wr), .cpu_addr_in(adr),
    .cpu_wdata_in(wd), .cpu_rdata_out(rd), .cpu_ack_out(ack),
    .timing_out(tim), .pair_out(pr), .input_select_reserved_out(rsv));
  stc_host stc_host_i (.sys_clk_in, .cpu_ack_in(ack), .cpu_rdata_in(rd),
    .cpu_select_out(sel), .cpu_write_out(wr), .cpu_addr_out(adr),
    .cpu_wdata_out(wd));
  task automatic chk(input string nm, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic tally_and_finish();
    if (n_fail == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish
  // a hang is cut short well past the roughly 50 cycles the run needs
  always @(posedge sys_clk_in) begin
    cyc++;
    if (cyc == 2000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  // main sequence: every word is written, read back and decoded
  initial begin
    repeat (3) @(negedge sys_clk_in);
    rst_in = 1'b0;
    stc_host_i.access(1'b0, 12'h000, 16'h0000, q);
    chk("reset_word", 32'h0, q);
    foreach (words[i]) begin
      w = words[i];
      stc_host_i.access(1'b1, 12'h000, w, q);
      stc_host_i.access(1'b0, 12'h000, 16'h0000, q);
      chk("readback", w, q);
      chk("disc", w[15] & w[13], tim.discriminator_enable);
      chk("jitter", {w[15] & w[13], 1'b0}, tim.jitter_window_cycles);
      chk("bypass", w[14], tim.pll_bypass);
      chk("in_khz", 16'h4000 >> w[12:10], tim.input_clock_khz);
      chk("in_ns", 8'h3D << w[12:10], tim.input_pulse_low_ns);
      chk("pair2", w[9] ? 24'h40003D : 24'h80001E, pr[2]);
      chk("pair1", w[8] ? 24'h20007A : 24'h40003D, pr[1]);
      chk("pair0", w[7] ? 24'h20007A : 24'h1000F4, pr[0]);
      chk("reserved", 1'b0, rsv);
    end
    stc_host_i.access(1'b1, 12'h000, stc_host_i.NORMAL_MODE, q);
    stc_host_i.access(1'b1, 12'h001, 16'h5A5A, q);
    stc_host_i.access(1'b0, 12'h001, 16'h0000, q);
    chk("unmapped", 32'h0, q);
    stc_host_i.access(1'b0, 12'h000, 16'h0000, q);
    chk("kept", 16'hA000, q);
    chk("disc_on", 1'b1, tim.discriminator_enable);
    // a second reset in mid-run must drop the discriminator again
    @(negedge sys_clk_in);
    rst_in = 1'b1;
    repeat (3) @(negedge sys_clk_in);
    rst_in = 1'b0;
    stc_host_i.access(1'b0, 12'h000, 16'h0000, q);
    chk("reset_again", 32'h0, q);
    chk("disc_off", 1'b0, tim.discriminator_enable);
    chk("pair2_rst", 24'h80001E, pr[2]);
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
